// ### bench/testbench.sv
`timescale 1ns/1ps
`include "ppt_regs.svh"
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    ppt_pkg::ppt_port_ctrl_t port_cfg [`PPT_NUM_PORTS];
    logic [11:0] vlan_id [`PPT_NUM_PORTS];
    ppt_pkg::ppt_cls_req_t cls_req = '0;
    ppt_pkg::ppt_cls_rsp_t cls_rsp;
    ppt_pkg::ppt_tag_req_t tag_req = '0;
    ppt_pkg::ppt_tag_rsp_t tag_rsp;
    int fail_count = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic [31:0] d;
    logic [1:0] q;
    logic hit;
    logic storm;
    int p;
    int g;

    always #20 hclk = ~hclk;

    // single slave, so its ready is the bus ready
    ppt_port_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .port_cfg(port_cfg),
        .port_default_vlan_id(vlan_id), .cls_req(cls_req), .cls_rsp(cls_rsp),
        .tag_req(tag_req), .tag_rsp(tag_rsp));

    task automatic final_report();
        if (fail_count == 0 && tests_run > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // bounded: a stuck ready ends the run instead of hanging it
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge hclk);
        end
        if (n >= 16)
        begin
            check("hready", {31'h0, hready}, 32'h1);
            final_report();
        end
    endtask

    // entered right after a rising edge; address phase, then data phase
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= data;
        wait_ready();
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    initial
    begin
        for (int k = 0; k < `PPT_NUM_PORTS; k++)
        begin
            vlan_id[k] = 12'hA51 + 12'(k * 12'h111);
        end
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k < `PPT_NUM_PORTS; k++)
        begin
            ahb(1'b0, 32'h10 * (k + 1), 32'h0);
            check("reset_read", rd, 32'h0);
            check("reset_cfg", port_cfg[k], 32'h0);
        end
        // upper data bits set on purpose: only the low byte may be kept
        for (int k = 0; k < `PPT_NUM_PORTS; k++)
        begin
            d = {24'hFFFFFF, 8'hE9 ^ 8'(k * 19)};
            ahb(1'b1, 32'h10 * (k + 1), d);
            ahb(1'b0, 32'h10 * (k + 1), 32'h0);
            check("reg_read", rd, {24'h0, d[7:0]});
            check("reg_cfg", port_cfg[k], d[7:0]);
        end
        ahb(1'b1, 32'h0000_0014, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h0000_0014, 32'h0);
        check("unmapped_read", rd, 32'h0);
        ahb(1'b0, 32'h0000_0010, 32'h0);
        check("port1_kept", rd, {24'h0, 8'hE9});
        // every enable and hit combination, all default queues, ports in turn
        for (int i = 0; i < 32; i++)
        begin
            p = i % 5;
            storm = i[0] ^ i[4];
            ahb(1'b1, 32'h10 * (p + 1), {24'h0, storm, i[0], i[1], i[4:3], 3'h1});
            cls_req <= '{valid: 1'b1, port: 3'(p), dsv_hit: i[2], dsv_prio: 2'h1,
                dot1p_hit: i[3], dot1p_prio: 2'h2};
            q = 2'h0;
            hit = 1'b0;
            if (i[0] && i[2])
            begin
                q = q | 2'h1;
                hit = 1'b1;
            end
            if (i[1] && i[3])
            begin
                q = q | 2'h2;
                hit = 1'b1;
            end
            if (!hit)
            begin
                q = 2'(i[4:3]);
            end
            @(posedge hclk);
            cls_req.valid <= 1'b0;
            @(negedge hclk);
            check("cls_rsp", {cls_rsp.valid, cls_rsp.storm_en, cls_rsp.queue}, {1'b1, storm, q});
            @(posedge hclk);
        end
        // vid must follow the ingress port, so ingress and egress always differ
        for (int j = 0; j < 20; j++)
        begin
            p = j % 5;
            g = (j + 2) % 5;
            ahb(1'b1, 32'h10 * (p + 1), {24'h0, 5'h0, j[0], j[1], 1'b1});
            tag_req <= '{valid: 1'b1, ingress_port: 3'(g), egress_port: 3'(p),
                rx_tagged: j[2]};
            @(posedge hclk);
            tag_req.valid <= 1'b0;
            @(negedge hclk);
            check("tag_rsp", {tag_rsp.valid, tag_rsp.add_tag, tag_rsp.strip_tag, tag_rsp.vid}, {1'b1, j[0] & ~j[2], j[1] & j[2], vlan_id[g]});
            @(posedge hclk);
        end
        // an index past the last port must give all-off answers
        cls_req <= '{valid: 1'b1, port: 3'h5, dsv_hit: 1'b1, dsv_prio: 2'h3,
            dot1p_hit: 1'b1, dot1p_prio: 2'h3};
        tag_req <= '{valid: 1'b1, ingress_port: 3'h7, egress_port: 3'h5, rx_tagged: 1'b0};
        @(posedge hclk);
        cls_req.valid <= 1'b0;
        tag_req.valid <= 1'b0;
        @(negedge hclk);
        check("cls_range", {cls_rsp.valid, cls_rsp.storm_en, cls_rsp.queue}, 4'h8);
        check("tag_range", {tag_rsp.valid, tag_rsp.add_tag, tag_rsp.strip_tag, tag_rsp.vid},
            15'h4000);
        final_report();
    end
endmodule // testbench

// ### verilog/ppt_pkg.sv
package ppt_pkg;

    // field order matches bit 7 down to bit 0 of each port control register
    typedef struct packed {
        logic storm_en;
        logic diffserv_en;
        logic dot1p_en;
        logic [1:0] def_prio;
        logic tag_ins;
        logic tag_rem;
        logic qsplit;
    } ppt_port_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [2:0] port;
        logic dsv_hit;
        logic [1:0] dsv_prio;
        logic dot1p_hit;
        logic [1:0] dot1p_prio;
    } ppt_cls_req_t;

    typedef struct packed {
        logic valid;
        logic storm_en;
        logic [1:0] queue;
    } ppt_cls_rsp_t;

    typedef struct packed {
        logic valid;
        logic [2:0] ingress_port;
        logic [2:0] egress_port;
        logic rx_tagged;
    } ppt_tag_req_t;

    typedef struct packed {
        logic valid;
        logic add_tag;
        logic strip_tag;
        logic [11:0] vid;
    } ppt_tag_rsp_t;

endpackage

// ### verilog/ppt_port_ctrl.sv
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ppt_regs.svh"
module ppt_port_ctrl #(
    parameter int NUM_PORTS = `PPT_NUM_PORTS,
    parameter int VID_W = `PPT_VID_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output ppt_pkg::ppt_port_ctrl_t port_cfg [NUM_PORTS],
    input wire logic [VID_W-1:0] port_default_vlan_id [NUM_PORTS],
    input wire ppt_pkg::ppt_cls_req_t cls_req,
    output ppt_pkg::ppt_cls_rsp_t cls_rsp,
    input wire ppt_pkg::ppt_tag_req_t tag_req,
    output ppt_pkg::ppt_tag_rsp_t tag_rsp
);

    ppt_pkg::ppt_port_ctrl_t ctrl_ff [NUM_PORTS];
    logic wr_pend_ff;
    logic [2:0] wr_idx_ff;
    logic [31:0] hrdata_ff;
    ppt_pkg::ppt_cls_rsp_t cls_rsp_ff;
    ppt_pkg::ppt_tag_rsp_t tag_rsp_ff;

    // returns {hit, index}; only the NUM_PORTS port control register addresses hit
    function automatic logic [3:0] addr_decode(input logic [31:0] addr);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            if (addr == `PPT_PORT1_CTRL_OFS + 32'(i) * `PPT_PORT_CTRL_STRIDE)
            begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction

    function automatic logic port_ok(input logic [2:0] p);
        return 32'(p) < NUM_PORTS;
    endfunction

    // bus decode
    wire logic addr_phase = hsel && htrans[1] && hready;
    wire logic [3:0] dec = addr_decode(haddr);
    wire logic dec_hit = dec[3];
    wire logic [2:0] dec_idx = dec[2:0];
    wire logic nxt_wr_pend = addr_phase && hwrite && dec_hit;
    // a read right behind a write to the same register sees the new value
    wire logic fwd = wr_pend_ff && (wr_idx_ff == dec_idx);
    wire logic [7:0] rd_byte = fwd ? hwdata[7:0] : ctrl_ff[dec_idx];
    wire logic [31:0] nxt_hrdata = (addr_phase && !hwrite && dec_hit) ?
        {24'h00_0000, rd_byte} : 32'h0000_0000;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 3'h0;
            hrdata_ff <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_ff <= nxt_wr_pend;
            wr_idx_ff <= dec_idx;
            if (addr_phase)
            begin
                hrdata_ff <= nxt_hrdata;
            end
        end
    end

    // all eight bits stored as written, bit 0 included
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                ctrl_ff[i] <= `PPT_CTRL_RESET;
            end
        end
        else if (wr_pend_ff)
        begin
            ctrl_ff[wr_idx_ff] <= hwdata[7:0];
        end
    end

    assign port_cfg = ctrl_ff;

    // ingress classification; an out-of-range port falls back to all-off
    wire logic cls_port_ok = port_ok(cls_req.port);
    wire ppt_pkg::ppt_port_ctrl_t cls_ctrl = cls_port_ok ? ctrl_ff[cls_req.port] : '0;
    wire logic use_dsv = cls_ctrl.diffserv_en && cls_req.dsv_hit;
    wire logic use_p1p = cls_ctrl.dot1p_en && cls_req.dot1p_hit;
    // or-merging two queue numbers can raise priority; kept as the switch does
    wire logic [1:0] merged = (use_dsv ? cls_req.dsv_prio : 2'h0) |
        (use_p1p ? cls_req.dot1p_prio : 2'h0);
    wire logic [1:0] nxt_queue = (use_dsv || use_p1p) ? merged : cls_ctrl.def_prio;
    wire ppt_pkg::ppt_cls_rsp_t nxt_cls_rsp = '{valid: cls_req.valid,
        storm_en: cls_ctrl.storm_en, queue: nxt_queue};

    // egress tagging: controls of the egress port, id of the ingress port
    wire logic eg_ok = port_ok(tag_req.egress_port);
    wire logic ing_ok = port_ok(tag_req.ingress_port);
    wire ppt_pkg::ppt_port_ctrl_t eg_ctrl = eg_ok ? ctrl_ff[tag_req.egress_port] : '0;
    wire logic [VID_W-1:0] ing_vid = ing_ok ?
        port_default_vlan_id[tag_req.ingress_port] : '0;
    wire logic nxt_add = eg_ctrl.tag_ins && !tag_req.rx_tagged;
    wire logic nxt_strip = eg_ctrl.tag_rem && tag_req.rx_tagged;
    wire ppt_pkg::ppt_tag_rsp_t nxt_tag_rsp = '{valid: tag_req.valid,
        add_tag: nxt_add, strip_tag: nxt_strip, vid: 12'(ing_vid)};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cls_rsp_ff <= '0;
            tag_rsp_ff <= '0;
        end
        else
        begin
            cls_rsp_ff <= nxt_cls_rsp;
            tag_rsp_ff <= nxt_tag_rsp;
        end
    end

    assign cls_rsp = cls_rsp_ff;
    assign tag_rsp = tag_rsp_ff;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    storm_follow_a: assert property (
        cls_req.valid && cls_port_ok |=>
        cls_rsp.valid && cls_rsp.storm_en == $past(cls_ctrl.storm_en))
        else $error("storm enable does not follow port bit 7");

    diffserv_only_a: assert property (
        cls_req.valid && cls_ctrl.diffserv_en && cls_req.dsv_hit && !use_p1p |=>
        cls_rsp.queue == $past(cls_req.dsv_prio))
        else $error("diffserv result not used");

    dot1p_only_a: assert property (
        cls_req.valid && cls_ctrl.dot1p_en && cls_req.dot1p_hit && !use_dsv |=>
        cls_rsp.queue == $past(cls_req.dot1p_prio))
        else $error("802.1p result not used");

    default_prio_a: assert property (
        cls_req.valid && !use_dsv && !use_p1p |=>
        cls_rsp.queue == $past(cls_ctrl.def_prio))
        else $error("port default priority not applied");

    or_merge_a: assert property (
        cls_req.valid && use_dsv && use_p1p |=>
        cls_rsp.queue == ($past(cls_req.dsv_prio) | $past(cls_req.dot1p_prio)))
        else $error("classifier results not or-merged");

    tag_insert_a: assert property (
        tag_req.valid && eg_ok && !tag_req.rx_tagged |=>
        tag_rsp.valid && tag_rsp.add_tag == $past(eg_ctrl.tag_ins))
        else $error("tag insertion wrong for untagged packet");

    no_double_tag_a: assert property (
        tag_req.valid && tag_req.rx_tagged |=> !tag_rsp.add_tag)
        else $error("second tag added to tagged packet");

    ingress_vid_a: assert property (
        tag_req.valid && ing_ok |=> tag_rsp.vid == $past(ing_vid))
        else $error("inserted id is not the ingress port id");

    tag_strip_a: assert property (
        tag_req.valid && eg_ok && tag_req.rx_tagged |=>
        tag_rsp.strip_tag == $past(eg_ctrl.tag_rem))
        else $error("tag removal does not follow port bit 1");

    untagged_keep_a: assert property (
        tag_req.valid && !tag_req.rx_tagged |=> !tag_rsp.strip_tag)
        else $error("strip flagged for untagged packet");

    reg_write_a: assert property (
        addr_phase && hwrite && dec_hit ##1 !(addr_phase && hwrite && dec_hit) |=>
        ctrl_ff[$past(dec_idx, 2)] == $past(hwdata[7:0]))
        else $error("register write not stored");

    read_back_a: assert property (
        addr_phase && !hwrite && !dec_hit |=> hrdata == 32'h0000_0000 && hreadyout)
        else $error("unmapped read not zero");

    qsplit_hold_a: assert property (
        !wr_pend_ff |=> $stable(port_cfg[0].qsplit) && $stable(port_cfg[NUM_PORTS-1].qsplit))
        else $error("queue split bit changed without a write");

    // extra guards on the bus side; reads and writes must not disturb each other
    ready_okay_a: assert property (
        hreadyout && !hresp)
        else $error("bus not ready or not okay");

    read_upper_a: assert property (
        hrdata[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");

    read_hold_a: assert property (
        !addr_phase |=> $stable(hrdata))
        else $error("read data changed without a transfer");

    read_data_a: assert property (
        addr_phase && !hwrite && dec_hit && !fwd |=>
        hrdata[7:0] == $past(ctrl_ff[dec_idx]))
        else $error("read data not the register value");

    // a read one cycle after a write to the same register takes hwdata directly
    read_forward_a: assert property (
        addr_phase && !hwrite && dec_hit && fwd |=>
        hrdata[7:0] == $past(hwdata[7:0]))
        else $error("read behind write missed the new value");

    unmapped_write_a: assert property (
        addr_phase && hwrite && !dec_hit |=> !wr_pend_ff)
        else $error("unmapped write accepted");

    write_index_a: assert property (
        nxt_wr_pend |=> wr_pend_ff && wr_idx_ff == $past(dec_idx))
        else $error("write index not captured");

    // middle ports only; for the end ports qsplit_hold_a watches only the qsplit bit
    no_write_hold_a: assert property (
        !wr_pend_ff |=> $stable(port_cfg[1]) && $stable(port_cfg[2]) && $stable(port_cfg[3]))
        else $error("register changed without a write");

    // out-of-range ports must read as all-off, never as a neighbour's settings
    cls_range_a: assert property (
        cls_req.valid && !cls_port_ok |=>
        cls_rsp.queue == 2'h0 && !cls_rsp.storm_en)
        else $error("out-of-range port not all-off");

    cls_pulse_a: assert property (
        cls_rsp.valid == $past(cls_req.valid))
        else $error("classify answer not one cycle after request");

    storm_off_a: assert property (
        cls_req.valid && cls_port_ok && !cls_ctrl.storm_en |=> !cls_rsp.storm_en)
        else $error("storm protection on with bit 7 clear");

    dsv_off_a: assert property (
        cls_req.valid && !cls_ctrl.diffserv_en && !use_p1p |=>
        cls_rsp.queue == $past(cls_ctrl.def_prio))
        else $error("disabled diffserv still classified");

    p1p_off_a: assert property (
        cls_req.valid && !cls_ctrl.dot1p_en && !use_dsv |=>
        cls_rsp.queue == $past(cls_ctrl.def_prio))
        else $error("disabled 802.1p still classified");

    // tagging controls come from the egress port only
    tag_pulse_a: assert property (
        tag_rsp.valid == $past(tag_req.valid))
        else $error("tag answer not one cycle after request");

    // a bad index falls back to zero so it never reads past the array
    tag_range_a: assert property (
        tag_req.valid && !eg_ok |=> !tag_rsp.add_tag && !tag_rsp.strip_tag)
        else $error("out-of-range egress port tagged");

    vid_range_a: assert property (
        tag_req.valid && !ing_ok |=> tag_rsp.vid == 12'h000)
        else $error("out-of-range ingress port gave an id");

    ins_off_a: assert property (
        tag_req.valid && eg_ok && !eg_ctrl.tag_ins |=> !tag_rsp.add_tag)
        else $error("tag added with insertion off");

    rem_off_a: assert property (
        tag_req.valid && eg_ok && !eg_ctrl.tag_rem |=> !tag_rsp.strip_tag)
        else $error("tag stripped with removal off");

endmodule // ppt_port_ctrl

// ### verilog/ppt_regs.svh
`ifndef PPT_REGS_SVH
`define PPT_REGS_SVH

`define PPT_NUM_PORTS 5
`define PPT_PORT1_CTRL_OFS 32'h0000_0010
`define PPT_PORT2_CTRL_OFS 32'h0000_0020
`define PPT_PORT3_CTRL_OFS 32'h0000_0030
`define PPT_PORT4_CTRL_OFS 32'h0000_0040
`define PPT_PORT5_CTRL_OFS 32'h0000_0050
`define PPT_PORT_CTRL_STRIDE 32'h0000_0010

`define PPT_STORM_EN_BIT 7
`define PPT_DIFFSERV_EN_BIT 6
`define PPT_DOT1P_EN_BIT 5
`define PPT_DEF_PRIO_MSB 4
`define PPT_DEF_PRIO_LSB 3
`define PPT_TAG_INS_BIT 2
`define PPT_TAG_REM_BIT 1
`define PPT_QSPLIT_BIT 0

`define PPT_CTRL_RESET 8'h00
`define PPT_VID_W 12

`endif
